// ---- hw/cplfc_consts.svh ----
// register map, field positions, reset values and fixed shifts of the cdr loop filter config
`ifndef CPLFC_CONSTS_SVH
`define CPLFC_CONSTS_SVH

// ****************************************************************
// register indices and byte addresses
// ****************************************************************
`define CPLFC_IDX_PROP 12'h046
`define CPLFC_IDX_INT 12'h047
`define CPLFC_IDX_ACQ 12'h048
`define CPLFC_IDX_STAT 12'h050
`define CPLFC_ADDR_PROP (`CPLFC_IDX_PROP * 12'h004)
`define CPLFC_ADDR_INT (`CPLFC_IDX_INT * 12'h004)
`define CPLFC_ADDR_ACQ (`CPLFC_IDX_ACQ * 12'h004)
`define CPLFC_ADDR_STAT (`CPLFC_IDX_STAT * 12'h004)

// ****************************************************************
// reset values
// ****************************************************************
`define CPLFC_RST_PROP 8'he6
`define CPLFC_RST_INT 8'h65
`define CPLFC_RST_ACQ 3'h1

// ****************************************************************
// field positions (lsb), two bits except the one-bit outer dead zone, inner dead zone and rate limit enable
// ****************************************************************
`define CPLFC_F_PEAK_SLEW 6
`define CPLFC_F_OUTER_DZ 5
`define CPLFC_F_INNER_DZ 4
`define CPLFC_F_PROP_GAIN 2
`define CPLFC_F_PROP_SAT 0
`define CPLFC_F_EXTRAP_SCALE 6
`define CPLFC_F_INT_PATH_SAT 4
`define CPLFC_F_INT_GAIN 2
`define CPLFC_F_INT_ACC_SAT 0
`define CPLFC_F_RATE_LIMIT_EN 2
`define CPLFC_F_PREAMBLE_LEN 0

// ****************************************************************
// arithmetic constants, in 1/16 bit units, shift counts or chips
// ****************************************************************
`define CPLFC_OUTER_DZ_LIMIT 7
`define CPLFC_INNER_DZ_LIMIT 1
`define CPLFC_INT_GAIN_BASE_SHIFT 5
`define CPLFC_EXTRAP_BASE_SHIFT 2
`define CPLFC_PREAMBLE_MAX_CHIPS 8

`endif

// ---- hw/cplfc_pkg.sv ----
// types of the cdr loop filter config block
package cplfc_pkg;

    typedef enum logic [2:0] {
        CPLFC_ACQ_IDLE = 3'b001,
        CPLFC_ACQ_RUN = 3'b010,
        CPLFC_ACQ_DONE = 3'b100
    } cplfc_acq_e;

    typedef enum logic [2:0] {
        CPLFC_SEL_NONE = 3'h0,
        CPLFC_SEL_PROP = 3'h1,
        CPLFC_SEL_INT = 3'h2,
        CPLFC_SEL_ACQ = 3'h3,
        CPLFC_SEL_STAT = 3'h4
    } cplfc_sel_e;

endpackage

// ---- hw/cplfc_top.sv ----
// cdr pi loop filter with its configuration registers on apb
`timescale 1ns/1ps
`include "cplfc_consts.svh"

// Contract
// - peak detector slew rate from two-bit select
// - outer dead zone zeroes error above 7/16
// - inner dead zone zeroes error below 1/16
// - proportional gain 1, 1/2, 1/4, 1/8
// - proportional path saturates at 1,2,4,8 sixteenths
// - phase error resolution is one sixteenth bit
// - extrapolation scaled 1/4 to 1/32 before load
// - preamble measures rate error, loads integral accumulator
// - integral path saturates 1/32 to 4/16 bit
// - integral gain 1/32 down to 1/256
// - integral accumulator saturates 1 to 8 sixteenths
// - rate limit enable bounds accepted rate error
// - preamble length 8, 7, 6, 5 chips
// - reset values e6, 65, 01, unused bits zero
module cplfc_top
    import cplfc_pkg::*;
#(
    parameter int EW = 6,
    parameter int FRAC = 8,
    parameter int PW = 8,
    parameter int RW = 12
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic signed [EW-1:0] PHASE_ERROR,
    input wire logic PHASE_VALID,
    input wire logic CHIP_STROBE,
    input wire logic PREAMBLE_START,
    input wire logic [PW-1:0] PEAK_SAMPLE,
    input wire logic signed [RW-1:0] RATE_UPPER_THRESHOLD,
    input wire logic signed [RW-1:0] RATE_LOWER_THRESHOLD,
    output logic signed [EW+FRAC+1:0] PHASE_CORRECTION,
    output logic [PW-1:0] PEAK_LEVEL,
    output logic signed [RW-1:0] RATE_ERROR,
    output logic INTEGRAL_LOADED
);

    localparam int AW = EW + FRAC + 2;

    typedef struct packed {
        logic [7:0] prop_cfg;
        logic [7:0] int_cfg;
        logic [2:0] acq_cfg;
        logic [31:0] prdata;
        cplfc_acq_e acq;
        logic [3:0] chip_cnt;
        logic signed [RW-1:0] rate_sum;
        logic signed [RW-1:0] rate_meas;
        logic signed [AW-1:0] acc;
        logic signed [AW-1:0] corr;
        logic [PW+FRAC-1:0] peak;
        logic loaded;
        logic rejected;
    } cplfc_state_s;

    cplfc_state_s st_ff;
    cplfc_state_s nxt_st;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic cplfc_sel_e addr_sel(input logic [11:0] a);
        cplfc_sel_e s;
        s = CPLFC_SEL_NONE;
        if (a == `CPLFC_ADDR_PROP) begin
            s = CPLFC_SEL_PROP;
        end else if (a == `CPLFC_ADDR_INT) begin
            s = CPLFC_SEL_INT;
        end else if (a == `CPLFC_ADDR_ACQ) begin
            s = CPLFC_SEL_ACQ;
        end else if (a == `CPLFC_ADDR_STAT) begin
            s = CPLFC_SEL_STAT;
        end
        return s;
    endfunction

    // symmetric clip to +-lim
    function automatic logic signed [31:0] sat(input logic signed [31:0] v,
                                               input logic signed [31:0] lim);
        logic signed [31:0] r;
        r = v;
        if (v > lim) begin
            r = lim;
        end else if (v < -lim) begin
            r = -lim;
        end
        return r;
    endfunction

    function automatic logic signed [31:0] pow2(input int sh);
        return 32'sh1 <<< sh;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        cplfc_sel_e sel;
        logic [1:0] slew_sel;
        logic [1:0] pgain;
        logic [1:0] proportional_saturation;
        logic [1:0] escale;
        logic [1:0] integral_path_saturation;
        logic [1:0] igain;
        logic [1:0] integral_accumulator_saturation;
        logic signed [31:0] e;
        logic signed [31:0] mag;
        logic signed [31:0] dz;
        logic signed [31:0] fix;
        logic signed [31:0] p_term;
        logic signed [31:0] i_step;
        logic signed [31:0] acc_sum;
        logic signed [31:0] ext;
        logic signed [31:0] rs;
        logic [3:0] run_len;
        logic [PW+FRAC-1:0] smp;
        logic [PW+FRAC-1:0] dpk;
        int up_sh;
        int dn_sh;
        sel = addr_sel(PADDR);
        slew_sel = st_ff.prop_cfg[`CPLFC_F_PEAK_SLEW +: 2];
        pgain = st_ff.prop_cfg[`CPLFC_F_PROP_GAIN +: 2];
        proportional_saturation = st_ff.prop_cfg[`CPLFC_F_PROP_SAT +: 2];
        escale = st_ff.int_cfg[`CPLFC_F_EXTRAP_SCALE +: 2];
        integral_path_saturation = st_ff.int_cfg[`CPLFC_F_INT_PATH_SAT +: 2];
        igain = st_ff.int_cfg[`CPLFC_F_INT_GAIN +: 2];
        integral_accumulator_saturation = st_ff.int_cfg[`CPLFC_F_INT_ACC_SAT +: 2];
        e = 32'(PHASE_ERROR);
        mag = (e < 0) ? -e : e;
        dz = e;
        fix = '0;
        p_term = '0;
        i_step = '0;
        acc_sum = '0;
        ext = '0;
        rs = 32'(st_ff.rate_sum);
        run_len = 4'(`CPLFC_PREAMBLE_MAX_CHIPS) - {2'h0, st_ff.acq_cfg[`CPLFC_F_PREAMBLE_LEN +: 2]};
        smp = {PEAK_SAMPLE, FRAC'(0)};
        dpk = '0;
        up_sh = 0;
        dn_sh = 0;
        nxt_st = st_ff;
        nxt_st.loaded = 1'b0;

        // apb: read data latched in setup, writes in access phase
        if (PSEL && !PENABLE) begin
            nxt_st.prdata = 32'h0;
            unique case (sel)
                CPLFC_SEL_PROP: nxt_st.prdata = {24'h0, st_ff.prop_cfg};
                CPLFC_SEL_INT: nxt_st.prdata = {24'h0, st_ff.int_cfg};
                CPLFC_SEL_ACQ: nxt_st.prdata = {29'h0, st_ff.acq_cfg};
                CPLFC_SEL_STAT: nxt_st.prdata = {16'h0, st_ff.peak[PW+FRAC-1:FRAC], 4'h0,
                    st_ff.rejected, st_ff.acq == CPLFC_ACQ_DONE, st_ff.acq == CPLFC_ACQ_RUN,
                    st_ff.acq == CPLFC_ACQ_IDLE};
                CPLFC_SEL_NONE: nxt_st.prdata = 32'h0;
            endcase
        end
        if (PSEL && PENABLE && PWRITE) begin
            unique case (sel)
                CPLFC_SEL_PROP: nxt_st.prop_cfg = PWDATA[7:0];
                CPLFC_SEL_INT: nxt_st.int_cfg = PWDATA[7:0];
                CPLFC_SEL_ACQ: nxt_st.acq_cfg = PWDATA[2:0];
                CPLFC_SEL_STAT, CPLFC_SEL_NONE: nxt_st.acq_cfg = st_ff.acq_cfg;
            endcase
        end

        // dead zones ahead of both gains
        if (st_ff.prop_cfg[`CPLFC_F_OUTER_DZ] && mag > `CPLFC_OUTER_DZ_LIMIT) begin
            dz = '0;
        end
        if (st_ff.prop_cfg[`CPLFC_F_INNER_DZ] && mag < `CPLFC_INNER_DZ_LIMIT) begin
            dz = '0;
        end
        fix = dz <<< FRAC;

        // pi filter
        p_term = sat(fix >>> pgain, pow2(FRAC + int'(proportional_saturation)));
        i_step = sat(fix >>> (`CPLFC_INT_GAIN_BASE_SHIFT + int'(igain)),
                     pow2(FRAC - 1 + int'(integral_path_saturation)));
        acc_sum = sat(32'(st_ff.acc) + i_step, pow2(FRAC + int'(integral_accumulator_saturation)));
        if (PHASE_VALID) begin
            nxt_st.acc = AW'(acc_sum);
            nxt_st.corr = AW'(p_term + acc_sum);
        end

        // peak detector with asymmetric slew, except select 0 where up and down shifts are both 6
        unique case (slew_sel)
            2'h0: begin
                up_sh = 6;
                dn_sh = 6;
            end
            2'h1: begin
                up_sh = 6;
                dn_sh = 7;
            end
            2'h2: begin
                up_sh = 5;
                dn_sh = 7;
            end
            2'h3: begin
                up_sh = 5;
                dn_sh = 8;
            end
        endcase
        if (PHASE_VALID) begin
            if (smp > st_ff.peak) begin
                dpk = (smp - st_ff.peak) >> up_sh;
                nxt_st.peak = st_ff.peak + dpk;
            end else begin
                dpk = (st_ff.peak - smp) >> dn_sh;
                nxt_st.peak = st_ff.peak - dpk;
            end
        end

        // acquisition preamble and rate extrapolation
        unique case (st_ff.acq)
            CPLFC_ACQ_IDLE, CPLFC_ACQ_DONE: begin
                nxt_st.acq = st_ff.acq;
            end
            CPLFC_ACQ_RUN: begin
                if (PHASE_VALID) begin
                    nxt_st.rate_sum = RW'(rs + e);
                end
                if (CHIP_STROBE) begin
                    nxt_st.chip_cnt = st_ff.chip_cnt + 4'h1;
                    if (st_ff.chip_cnt + 4'h1 >= run_len) begin
                        nxt_st.acq = CPLFC_ACQ_DONE;
                        nxt_st.rate_meas = st_ff.rate_sum;
                        ext = (rs <<< FRAC) >>> (`CPLFC_EXTRAP_BASE_SHIFT + int'(escale));
                        if (st_ff.acq_cfg[`CPLFC_F_RATE_LIMIT_EN] &&
                            (st_ff.rate_sum > RATE_UPPER_THRESHOLD ||
                             st_ff.rate_sum < RATE_LOWER_THRESHOLD)) begin
                            nxt_st.rejected = 1'b1;
                        end else begin
                            nxt_st.acc = AW'(sat(ext, pow2(FRAC + int'(integral_accumulator_saturation))));
                            nxt_st.loaded = 1'b1;
                        end
                    end
                end
            end
            default: begin
                nxt_st.acq = CPLFC_ACQ_IDLE;
            end
        endcase
        if (PREAMBLE_START) begin
            nxt_st.acq = CPLFC_ACQ_RUN;
            nxt_st.chip_cnt = 4'h0;
            nxt_st.rate_sum = '0;
            nxt_st.rejected = 1'b0;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            st_ff <= '0;
            st_ff.prop_cfg <= `CPLFC_RST_PROP;
            st_ff.int_cfg <= `CPLFC_RST_INT;
            st_ff.acq_cfg <= `CPLFC_RST_ACQ;
            st_ff.acq <= CPLFC_ACQ_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && (addr_sel(PADDR) == CPLFC_SEL_NONE ||
                     (PWRITE && addr_sel(PADDR) == CPLFC_SEL_STAT));
    assign PRDATA = st_ff.prdata;
    assign PHASE_CORRECTION = st_ff.corr;
    assign PEAK_LEVEL = st_ff.peak[PW+FRAC-1:FRAC];
    assign RATE_ERROR = st_ff.rate_meas;
    assign INTEGRAL_LOADED = st_ff.loaded;

endmodule

// ---- bench/cplfc_top_assertions.sv ----
// concurrent checks on the ports of the cdr loop filter block
`timescale 1ns/1ps
`include "cplfc_consts.svh"
module cplfc_top_assertions #(
    parameter int EW = 6,
    parameter int FRAC = 8,
    parameter int PW = 8,
    parameter int RW = 12
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [11:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic signed [EW-1:0] PHASE_ERROR,
    input wire logic PHASE_VALID,
    input wire logic CHIP_STROBE,
    input wire logic [PW-1:0] PEAK_SAMPLE,
    input wire logic [PW-1:0] PEAK_LEVEL,
    input wire logic signed [EW+FRAC+1:0] PHASE_CORRECTION,
    input wire logic signed [RW-1:0] RATE_ERROR,
    input wire logic INTEGRAL_LOADED
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    property p_rst; $rose(RSTN) |-> PHASE_CORRECTION == 0 && RATE_ERROR == 0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_rdy; PSEL |-> PREADY; endproperty
    a_rdy: assert property (p_rdy) else $error("apb slave stalled");
    property p_err; PSEL && PENABLE && !(PADDR inside {`CPLFC_ADDR_PROP, `CPLFC_ADDR_INT,
        `CPLFC_ADDR_ACQ, `CPLFC_ADDR_STAT}) |-> PSLVERR; endproperty
    a_err: assert property (p_err) else $error("unmapped access not flagged");
    property p_hold; !PHASE_VALID |=> $stable(PHASE_CORRECTION); endproperty
    a_hold: assert property (p_hold) else $error("correction moved without sample");
    property p_sat; PHASE_CORRECTION <= 4096 && PHASE_CORRECTION >= -4096; endproperty
    a_sat: assert property (p_sat) else $error("correction beyond saturation");
    property p_pkh; !PHASE_VALID |=> $stable(PEAK_LEVEL); endproperty
    a_pkh: assert property (p_pkh) else $error("peak level moved without sample");
    property p_pkd; PHASE_VALID && PEAK_SAMPLE < PEAK_LEVEL |=> PEAK_LEVEL <= $past(PEAK_LEVEL);
    endproperty
    a_pkd: assert property (p_pkd) else $error("peak level rose on smaller sample");
    property p_ld; INTEGRAL_LOADED |-> $past(CHIP_STROBE) ##1 !INTEGRAL_LOADED; endproperty
    a_ld: assert property (p_ld) else $error("load pulse not after chip strobe");
    property p_rate; !CHIP_STROBE |=> $stable(RATE_ERROR); endproperty
    a_rate: assert property (p_rate) else $error("rate error moved off a chip");
    c_load: cover property (INTEGRAL_LOADED);
    c_err: cover property (PSLVERR);
    c_outer: cover property (PHASE_VALID && PHASE_ERROR > 7);
endmodule

// ---- bench/cplfc_demod.sv ----
// demodulator model feeding phase samples, peak samples and chip strobes
`timescale 1ns/1ps
module cplfc_demod (
    input wire logic clk,
    output logic signed [5:0] phase_error,
    output logic phase_valid,
    output logic chip_strobe,
    output logic preamble_start,
    output logic [7:0] peak_sample
);
    initial begin
        phase_error = 6'h2a;
        phase_valid = 1'b0;
        chip_strobe = 1'b0;
        preamble_start = 1'b0;
        peak_sample = 8'h55;
    end
    // one sample, then released lines show the inverse
    task automatic sample(input logic signed [5:0] e, input logic [7:0] pk, input int gap);
        phase_error <= e;
        peak_sample <= pk;
        phase_valid <= 1'b1;
        @(posedge clk);
        phase_valid <= 1'b0;
        phase_error <= ~e;
        peak_sample <= ~pk;
        repeat (gap + 1) @(posedge clk);
    endtask
    task automatic pulse(input bit start);
        if (start) preamble_start <= 1'b1;
        else chip_strobe <= 1'b1;
        @(posedge clk);
        preamble_start <= 1'b0;
        chip_strobe <= 1'b0;
    endtask
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the cdr loop filter configuration block
`timescale 1ns/1ps
`include "cplfc_consts.svh"
module testbench;
    logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, pvalid, cstrobe, pstart, loaded;
    logic signed [11:0] rate_hi = 12'h064, rate_lo = 12'hf9c, rate_err;
    logic signed [5:0] perr;
    logic signed [15:0] corr;
    logic [7:0] psamp, peak_lvl, pc = 8'he6, ic = 8'h65;
    int n_fail = 0, check_count = 0, acc = 0, lvl = 0;
    int errs[8] = '{9, -9, 8, 7, -1, 0, 31, -32};
    always #25 clk_sys = ~clk_sys;
    cplfc_top dut (.CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PHASE_ERROR(perr), .PHASE_VALID(pvalid), .CHIP_STROBE(cstrobe),
        .PREAMBLE_START(pstart), .PEAK_SAMPLE(psamp), .RATE_UPPER_THRESHOLD(rate_hi),
        .RATE_LOWER_THRESHOLD(rate_lo), .PHASE_CORRECTION(corr), .PEAK_LEVEL(peak_lvl),
        .RATE_ERROR(rate_err), .INTEGRAL_LOADED(loaded));
    cplfc_demod dem (.clk(clk_sys), .phase_error(perr), .phase_valid(pvalid),
        .chip_strobe(cstrobe), .preamble_start(pstart), .peak_sample(psamp));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            print_verdict();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    function automatic int sat(input int v, input int l);
        return (v > l) ? l : ((v < -l) ? -l : v);
    endfunction
    task automatic step(input int e, input int pk, input bit chk);
        int d;
        int pt;
        int df;
        d = ((pc[5] && (e > 7 || e < -7)) || (pc[4] && e == 0)) ? 0 : e;
        pt = sat((d * 256) >>> pc[3:2], 2 ** (8 + pc[1:0]));
        acc = sat(acc + sat((d * 256) >>> (5 + ic[3:2]), 2 ** (7 + ic[5:4])), 2 ** (8 + ic[1:0]));
        df = pk * 256 - lvl;
        lvl = lvl + ((df >= 0) ? (df >>> (pc[7] ? 5 : 6)) : -((-df) >>> (6 + pc[7] + pc[6])));
        dem.sample(6'(e), 8'(pk), pk & 1);
        if (chk) check(32'(corr), 32'(pt + acc));
        check(32'(peak_lvl), 32'(lvl >>> 8));
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs;
        apb(0, `CPLFC_ADDR_PROP, 0);
        check(q, 32'(`CPLFC_RST_PROP));
        apb(0, `CPLFC_ADDR_INT, 0);
        check(q, 32'(`CPLFC_RST_INT));
        apb(0, `CPLFC_ADDR_ACQ, 0);
        check(q, 32'(`CPLFC_RST_ACQ));
        apb(0, `CPLFC_ADDR_STAT, 0);
        check(q, 32'h1);
        apb(1, `CPLFC_ADDR_ACQ, 32'hffffffff);
        apb(0, `CPLFC_ADDR_ACQ, 0);
        check(q, 32'h7);
        apb(0, 12'h000, 0);
        check({q[30:0], err}, 32'h1);
        apb(1, `CPLFC_ADDR_STAT, 32'hff);
        check(32'(err), 32'h1);
    endtask
    task automatic t_loop;
        for (int k = 0; k < 4; k++) begin
            pc = {2'(k), k[0], k[1], 2'(k), 2'(3 - k)};
            ic = {2'(3 - k), 2'(k), 2'(k), 2'(k)};
            apb(1, `CPLFC_ADDR_PROP, 32'(pc));
            apb(1, `CPLFC_ADDR_INT, 32'(ic));
            foreach (errs[j]) step(errs[j], 60 * k + j, 1);
        end
    endtask
    task automatic t_acq(input logic [2:0] cfg, input int hi, input int lo);
        int n;
        bit rej;
        n = 8 - cfg[1:0];
        rej = cfg[2] && (3 * n > hi || 3 * n < lo);
        ic = {cfg[1:0], 6'h15};
        rate_hi <= 12'(hi);
        rate_lo <= 12'(lo);
        apb(1, `CPLFC_ADDR_INT, 32'(ic));
        apb(1, `CPLFC_ADDR_ACQ, 32'(cfg));
        dem.pulse(1);
        for (int k = 1; k <= n; k++) begin
            step(3, 9, 0);
            dem.pulse(0);
            @(negedge clk_sys);
            check(32'(loaded), 32'(k == n && !rej));
            @(posedge clk_sys);
        end
        check(32'(rate_err), 32'(3 * n));
        if (!rej) acc = sat((3 * n * 256) >>> (2 + ic[7:6]), 2 ** (8 + ic[1:0]));
        apb(0, `CPLFC_ADDR_STAT, 0);
        check(32'(q[3]), 32'(rej));
        check(q, {16'h0, 8'(lvl >>> 8), 4'h0, rej, 3'h4});
        step(2, 9, 1);
    endtask
    logic [2:0] cf[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h5};
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_loop();
        foreach (cf[k]) t_acq(cf[k], (cf[k] == 3'h7) ? 5 : 100, (cf[k] == 3'h5) ? 50 : -100);
        print_verdict();
    end
endmodule
bind cplfc_top cplfc_top_assertions #(.EW(EW), .FRAC(FRAC), .PW(PW), .RW(RW)) u_chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PHASE_ERROR(PHASE_ERROR), .PHASE_VALID(PHASE_VALID),
    .CHIP_STROBE(CHIP_STROBE), .PEAK_SAMPLE(PEAK_SAMPLE), .PEAK_LEVEL(PEAK_LEVEL),
    .PHASE_CORRECTION(PHASE_CORRECTION), .RATE_ERROR(RATE_ERROR),
    .INTEGRAL_LOADED(INTEGRAL_LOADED));
